// [dv/host_irq_fifo_clkout_tb.sv]
`timescale 1ns/10ps
module host_irq_fifo_clkout_tb
  import hostirq_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] ca = 4'h0;
  logic [7:0] cd = 8'h00;
  logic cw = 1'b0;
  logic cr = 1'b0;
  logic [7:0] ev [4] = '{default: 8'h00};
  logic rxs = 1'b0;
  logic rxv = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic txr = 1'b0;
  logic txs = 1'b0;
  logic xon = 1'b1;
  logic rcc = 1'b0;
  logic i2e = 1'b0;
  logic [7:0] crd, txd, q;
  logic hirq, tmo, tick, i2m;
  int failures = 0;
  int check_count = 0;
  always #10 clk_i = ~clk_i;
  always #160 rcc = ~rcc;
  host_link_if lk ();
  nfc_dev_end #(.DEPTH(FIFO_BYTES), .IRQ_BITS(8)) i_nfc_dev_end (.clk_i(clk_i), .rst_i(rst_i),
    .link(lk), .ev_main_i(ev[0]), .ev_timer_i(ev[1]), .ev_err_i(ev[2]), .ev_pt_i(ev[3]),
    .rx_start_i(rxs), .rx_valid_i(rxv), .rx_data_i(rxd), .tx_rd_i(txr), .tx_short_i(txs),
    .tx_data_o(txd), .xtal_on_i(xon), .rc_clk_i(rcc), .i2c_en_i(i2e), .i2c_mode_o(i2m),
    .stop_o());
  nfc_host_end #(.TIMEOUT_CYC(50)) i_nfc_host_end (.clk_i(clk_i), .rst_i(rst_i), .link(lk),
    .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_wr_i(cw), .cmd_rd_i(cr), .cmd_rdata_o(crd),
    .irq_o(hirq), .timeout_o(tmo), .mcu_tick_o(tick));
  host_link_properties i_host_link_properties (.clk_i(clk_i), .rst_i(rst_i), .addr(lk.addr),
    .wdata(lk.wdata), .wr(lk.wr), .rd(lk.rd), .rdata(lk.rdata), .irq(lk.irq),
    .mcu_clk(lk.mcu_clk));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ca <= a;
    cd <= d;
    cw <= 1'b1;
    @(posedge clk_i);
    cw <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    ca <= a;
    cr <= 1'b1;
    @(posedge clk_i);
    cr <= 1'b0;
    #1;
    q = crd;
  endtask
  task automatic ev_pulse(input int k, input logic [7:0] v);
    @(posedge clk_i);
    ev[k] <= v;
    @(posedge clk_i);
    ev[k] <= 8'h00;
    #1;
  endtask
  // one-cycle pulse on rx start, rx valid, tx pop or tx short
  task automatic ctl(input int k);
    @(posedge clk_i);
    {rxs, rxv, txr, txs} <= 4'h8 >> k;
    @(posedge clk_i);
    {rxs, rxv, txr, txs} <= 4'h0;
    #1;
  endtask
  task automatic s_irq();
    for (int k = 0; k < NUM_STAT; k++)
    begin
      ev_pulse(k, 8'h81 >> k);
      chk(lk.irq, 1'b1);
      rd(k[3:0]);
      chk(q, k == 0 ? 8'h81 : 8'h00);
      if (k != 0)
        rd(k[3:0]);
      chk(q, 8'h81 >> k);
      chk(lk.irq, 1'b0);
      rd(k[3:0]);
      chk(q, 8'h00);
    end
    ev_pulse(0, 8'h01);
    ev_pulse(3, 8'h10);
    rd(REG_STAT_MAIN);
    chk({hirq, lk.irq}, 2'h3);
    rd(REG_STAT_PT);
    chk({q, 7'h00, lk.irq}, 16'h1000);
    fork
      ev_pulse(1, 8'h04);
      rd(REG_STAT_TIMER);
    join
    rd(REG_STAT_MAIN);
    rd(REG_STAT_TIMER);
    chk(q, 8'h04);
  endtask
  task automatic s_mask();
    for (int k = 4; k < 8; k++)
      wr(k[3:0], 8'hFF);
    ev_pulse(0, 8'h20);
    chk(lk.irq, 1'b0);
    rd(4'h7);
    chk(q, 8'hFF);
    wr(REG_MASK_BASE, 8'h00);
    chk(lk.irq, 1'b1);
    wr(REG_MASK_BASE, 8'hFF);
    rd(REG_STAT_MAIN);
    chk(q, 8'h20);
    rd(REG_STAT_MAIN);
    chk(q, 8'h00);
    // masked event after a command: early status poll must be refused
    wr(REG_COMMAND, CMD_STOP_ALL);
    ev_pulse(0, 8'h02);
    rd(REG_STAT_MAIN);
    chk(q, 8'h00);
    rd(REG_FIFO_CNT);
    rd(REG_STAT_MAIN);
    chk(q, 8'h02);
    for (int k = 4; k < 8; k++)
      wr(k[3:0], 8'h00);
  endtask
  task automatic s_cmd();
    dir_cmd_t cmds [3] = '{CMD_SET_DEFAULT, CMD_STOP_ALL, CMD_CLEAR_FIFO};
    foreach (cmds[k])
    begin
      wr(REG_IO_CFG, 8'h03);
      ev_pulse(2, 8'h08);
      wr(REG_COMMAND, cmds[k]);
      chk(lk.irq, 1'b0);
      rd(REG_FIFO_CNT);
      rd(REG_STAT_MAIN);
      rd(REG_STAT_ERR);
      chk(q, 8'h00);
      rd(REG_IO_CFG);
      chk(q[2:0], k == 0 ? 3'h1 : 3'h3);
    end
    repeat (30) @(posedge clk_i);
    chk(tmo, 1'b0);
    repeat (30) @(posedge clk_i);
    chk(tmo, 1'b1);
  endtask
  task automatic s_fifo();
    ctl(0);
    @(posedge clk_i);
    rxv <= 1'b1;
    for (int i = 0; i < FIFO_BYTES; i++)
    begin
      rxd <= i[7:0];
      @(posedge clk_i);
    end
    rxv <= 1'b0;
    rd(REG_FIFO_STAT);
    chk(q, 8'h02);
    ctl(1);
    rd(REG_FIFO_STAT);
    chk(q, 8'h82);
    rd(REG_FIFO_DATA);
    rd(REG_FIFO_DATA);
    chk({q, txd}, 16'h0102);
    ctl(0);
    rd(REG_FIFO_DATA);
    chk(q, 8'h00);
    rd(REG_FIFO_STAT);
    chk(q, 8'h40);
    for (int a = 8; a < 11; a++)
    begin
      wr(REG_COMMAND, CMD_CLEAR_FIFO);
      rd(a[3:0]);
      chk(q, 8'h00);
    end
    ctl(3);
    rd(REG_FIFO_STAT);
    chk(q, 8'h40);
    wr(REG_COMMAND, CMD_CLEAR_FIFO);
    wr(REG_FIFO_DATA, 8'h5A);
    chk(txd, 8'h5A);
    ctl(2);
    chk(txd, 8'h00);
  endtask
  task automatic s_clk();
    int n;
    int m;
    logic p;
    logic [7:0] cfg [6] = '{8'h03, 8'h02, 8'h01, 8'h00, 8'h00, 8'h04};
    logic [15:0] exp [6] = '{16'h20, 16'h10, 16'h08, 16'h00, 16'h04, 16'h00};
    foreach (cfg[k])
    begin
      @(posedge clk_i);
      xon <= k < 4;
      wr(REG_IO_CFG, cfg[k]);
      repeat (16) @(posedge clk_i);
      n = 0;
      m = 0;
      @(negedge clk_i);
      p = lk.mcu_clk;
      repeat (64)
      begin
        @(negedge clk_i);
        n += (lk.mcu_clk === 1'b1 && p === 1'b0);
        m += (tick === 1'b1);
        p = lk.mcu_clk;
      end
      if (k < 4)
        chk(n[15:0], exp[k]);
      else
        chk(n[15:0], exp[k]);
      if (k > 1)
        chk(m[15:0], exp[k]);
    end
    @(posedge clk_i);
    i2e <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(REG_IO_CFG);
    chk({q[7], i2m}, 2'h3);
    @(posedge clk_i);
    i2e <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(i2m, 1'b0);
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_irq();
    s_mask();
    s_cmd();
    s_fifo();
    s_clk();
    wrap_up();
  end
  // hang guard, well beyond the roughly 1300 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
endmodule

// [dv/host_link_properties.sv]
`timescale 1ns/10ps
module host_link_properties
  import hostirq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic mcu_clk
);
  logic [7:0] mask_reg [4];
  logic [2:0] cfg_reg;
  logic [2:0] park_reg;
  wire cmd_wr = wr && addr == REG_COMMAND;
  wire def_cmd = cmd_wr && wdata == CMD_SET_DEFAULT;
  wire clr_cmd = cmd_wr && wdata == CMD_CLEAR_FIFO;
  wire all_masked = &{mask_reg[0], mask_reg[1], mask_reg[2], mask_reg[3]};
  wire parked = cfg_reg == 3'h4;
  // shadow of the mask and io config registers, seen from the link
  always_ff @(posedge clk_i)
  begin
    if (rst_i || def_cmd)
    begin
      mask_reg <= '{default: MASK_RESET};
      cfg_reg <= {LF_OFF_RESET, CLKSEL_RESET};
    end
    else if (wr && addr[3:2] == 2'h1)
      mask_reg[addr[1:0]] <= wdata;
    else if (wr && addr == REG_IO_CFG)
      cfg_reg <= wdata[2:0];
  end
  // cycles spent with the clock output fully parked
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !parked)
      park_reg <= 3'h0;
    else if (park_reg != 3'h7)
      park_reg <= park_reg + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_strobe_excl: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_masked_quiet: assert property (all_masked && $past(all_masked) |-> !irq)
    else $error("request high with all sources masked");
  a_cfg_readback: assert property (
    rd && addr == REG_IO_CFG |=> rdata[2:0] == $past(cfg_reg))
    else $error("io config readback wrong");
  a_mask_readback: assert property (rd && addr[3:2] == 2'h1 |=>
    rdata == $past(mask_reg[addr[1:0]]))
    else $error("mask readback wrong");
  a_flags_cleared: assert property (clr_cmd ##2 (rd && addr == REG_FIFO_STAT) |=>
    rdata[7:6] == 2'h0)
    else $error("fifo flags survive clear");
  a_fifo_zero: assert property (
    clr_cmd ##2 (rd && addr == REG_FIFO_DATA) |=> rdata == 8'h00)
    else $error("cleared fifo read not zero");
  a_count_zero: assert property (
    clr_cmd ##2 (rd && addr == REG_FIFO_CNT) |=> rdata == 8'h00)
    else $error("fifo count survives clear");
  a_clk_parked: assert property (park_reg == 3'h7 |-> !mcu_clk)
    else $error("clock output active while disabled");
endmodule

// [rtl/host_link_if.sv]
`timescale 1ns/10ps
interface host_link_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic mcu_clk;
  modport dev (input addr, input wdata, input wr, input rd,
    output rdata, output irq, output mcu_clk);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata, input irq, input mcu_clk);
endinterface

// [rtl/hostirq_pkg.sv]
// Functional notes
// - four separate interrupt status registers
// - event sets bit, raises request unless masked
// - host reads main status register first
// - status read returns value then clears
// - request stays high while unmasked bits pending
// - masked source records bit, no request
// - read clears masked bits too
// - unmasking pending bit raises request immediately
// - default, stop, clear-FIFO clear all status
// - polling host avoids early status reads
// - host keeps own receive-end timeout
// - 512-byte FIFO for transmit and receive
// - overflow flag beyond 512 bytes written
// - underflow on empty read or transmit shortfall
// - FIFO reset at receive start, power-up, default and clear-FIFO commands
// - empty FIFO reads return zero
// - two-bit select enables clock, picks division
// - low-frequency disable gates RC clock output
// - power-up default 3.39 MHz, low-frequency enabled
// - host framing runs from device clock output
// - strap selects serial or I2C slave
// - device only slave, host initiates all
package hostirq_pkg;
  localparam int FIFO_BYTES = 512;
  localparam int NUM_STAT = 4;
  // register indexes on the link
  localparam logic [3:0] REG_STAT_MAIN = 4'h0;
  localparam logic [3:0] REG_STAT_TIMER = 4'h1;
  localparam logic [3:0] REG_STAT_ERR = 4'h2;
  localparam logic [3:0] REG_STAT_PT = 4'h3;
  localparam logic [3:0] REG_MASK_BASE = 4'h4;
  localparam logic [3:0] REG_FIFO_DATA = 4'h8;
  localparam logic [3:0] REG_FIFO_CNT = 4'h9;
  localparam logic [3:0] REG_FIFO_STAT = 4'hA;
  localparam logic [3:0] REG_IO_CFG = 4'hB;
  localparam logic [3:0] REG_COMMAND = 4'hC;
  // fifo status field positions
  localparam int FST_OVF_BIT = 7;
  localparam int FST_UNF_BIT = 6;
  // io config field positions
  localparam int IOC_LF_OFF_BIT = 2;
  localparam int IOC_STRAP_BIT = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic LF_OFF_RESET = 1'b0;
  typedef enum logic [1:0] {
    CLKSEL_OFF = 2'b00,
    CLKSEL_3M39 = 2'b01,
    CLKSEL_6M78 = 2'b10,
    CLKSEL_13M56 = 2'b11
  } clk_sel_t;
  localparam clk_sel_t CLKSEL_RESET = CLKSEL_3M39;
  typedef enum logic [7:0] {
    CMD_SET_DEFAULT = 8'hC1,
    CMD_STOP_ALL = 8'hC2,
    CMD_CLEAR_FIFO = 8'hC3
  } dir_cmd_t;
  // host receive-end timeout
  localparam int RX_TIMEOUT_US = 5000;
  localparam int CLK_MHZ = 50;
  localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_US * CLK_MHZ;
  function automatic logic is_status(input logic [3:0] a);
    return a < REG_MASK_BASE;
  endfunction
endpackage

// [rtl/nfc_dev_end.sv]
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module nfc_dev_end
  import hostirq_pkg::*;
#(
  parameter int DEPTH = FIFO_BYTES,
  parameter int IRQ_BITS = 8
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to host
  host_link_if.dev link,
  // interrupt sources, one vector per status register
  input wire logic [IRQ_BITS-1:0] ev_main_i,
  input wire logic [IRQ_BITS-1:0] ev_timer_i,
  input wire logic [IRQ_BITS-1:0] ev_err_i,
  input wire logic [IRQ_BITS-1:0] ev_pt_i,
  // receive side of the fifo
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // transmit side of the fifo
  input wire logic tx_rd_i,
  input wire logic tx_short_i,
  output logic [7:0] tx_data_o,
  // clocks and straps
  input wire logic xtal_on_i,
  input wire logic rc_clk_i,
  input wire logic i2c_en_i,
  output logic i2c_mode_o,
  output logic stop_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [IRQ_BITS-1:0] stat_reg [NUM_STAT];
  logic [IRQ_BITS-1:0] stat_next [NUM_STAT];
  logic [IRQ_BITS-1:0] mask_reg [NUM_STAT];
  logic [IRQ_BITS-1:0] ev [NUM_STAT];
  logic irq_reg;
  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] cnt_reg;
  logic ovf_reg;
  logic unf_reg;
  logic [7:0] rdata_reg;
  clk_sel_t csel_reg;
  logic lf_off_reg;
  logic [2:0] div_reg;
  logic mclk_reg;
  logic [2:0] rc_sync_reg;
  logic rc_level_reg;
  logic [2:0] strap_sync_reg;
  logic strap_reg;

  wire cmd_wr = link.wr && link.addr == REG_COMMAND;
  wire set_dflt = cmd_wr && link.wdata == CMD_SET_DEFAULT;
  wire stop_all = cmd_wr && link.wdata == CMD_STOP_ALL;
  wire clr_fifo = cmd_wr && link.wdata == CMD_CLEAR_FIFO;
  wire clr_all_irq = set_dflt || stop_all || clr_fifo;
  wire fifo_rst = rx_start_i || set_dflt || clr_fifo;
  wire host_push = link.wr && link.addr == REG_FIFO_DATA;
  wire host_pop = link.rd && link.addr == REG_FIFO_DATA;
  wire push = host_push || rx_valid_i;
  wire pop = host_pop || tx_rd_i;
  wire fifo_empty = cnt_reg == '0;
  wire fifo_full = cnt_reg == CW'(DEPTH);
  wire do_push = push && !fifo_full;
  wire do_pop = pop && !fifo_empty;
  wire [7:0] fifo_head = fifo_empty ? 8'h00 : mem[rptr_reg];
  wire [CW-1:0] cnt_next = cnt_reg + CW'(do_push) - CW'(do_pop);
  wire [7:0] wr_byte = host_push ? link.wdata : rx_data_i;
  wire [1:0] stat_idx = link.addr[1:0];
  wire [1:0] mask_idx = link.addr[1:0];
  wire mask_wr = link.wr && link.addr[3:2] == REG_MASK_BASE[3:2];
  wire [IRQ_BITS-1:0] rd_stat = stat_reg[stat_idx];
  wire [IRQ_BITS-1:0] rd_mask = mask_reg[mask_idx];

  assign ev[0] = ev_main_i;
  assign ev[1] = ev_timer_i;
  assign ev[2] = ev_err_i;
  assign ev[3] = ev_pt_i;
  assign link.irq = irq_reg;
  assign link.rdata = rdata_reg;
  assign link.mcu_clk = mclk_reg;
  assign tx_data_o = fifo_head;
  assign i2c_mode_o = strap_reg;
  assign stop_o = 1'b0;

  // clear on read, new events win over the clear
  always_comb
  begin
    for (int i = 0; i < NUM_STAT; i++)
    begin
      stat_next[i] = stat_reg[i];
      if (link.rd && is_status(link.addr) && stat_idx == 2'(i))
        stat_next[i] = '0;
      if (clr_all_irq)
        stat_next[i] = '0;
      stat_next[i] = stat_next[i] | ev[i];
    end
  end

  // four status and four mask registers
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_STAT; i++)
    begin
      if (rst_i || set_dflt)
        mask_reg[i] <= MASK_RESET;
      else if (mask_wr && mask_idx == 2'(i))
        mask_reg[i] <= link.wdata[IRQ_BITS-1:0];
      stat_reg[i] <= rst_i ? '0 : stat_next[i];
    end
  end

  // request follows any unmasked pending bit, including newly unmasked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
    begin
      irq_reg <= 1'b0;
      for (int i = 0; i < NUM_STAT; i++)
      begin
        if (mask_wr && mask_idx == 2'(i))
        begin
          if (|(stat_next[i] & ~link.wdata[IRQ_BITS-1:0]))
            irq_reg <= 1'b1;
        end
        else if (|(stat_next[i] & ~mask_reg[i]))
          irq_reg <= 1'b1;
      end
    end
  end

  // fifo storage
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wptr_reg] <= wr_byte;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || fifo_rst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end
    else
    begin
      if (do_push)
        wptr_reg <= PW'(wptr_reg + 1'b1);
      if (do_pop)
        rptr_reg <= PW'(rptr_reg + 1'b1);
      cnt_reg <= cnt_next;
      if (push && fifo_full)
        ovf_reg <= 1'b1;
      if ((pop && fifo_empty) || tx_short_i)
        unf_reg <= 1'b1;
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 8'h00;
    else if (link.rd)
    begin
      rdata_reg <= 8'h00;
      if (is_status(link.addr))
        rdata_reg <= 8'(rd_stat);
      else if (link.addr[3:2] == REG_MASK_BASE[3:2])
        rdata_reg <= 8'(rd_mask);
      else if (link.addr == REG_FIFO_DATA)
        rdata_reg <= fifo_head;
      else if (link.addr == REG_FIFO_CNT)
        rdata_reg <= cnt_reg[7:0];
      else if (link.addr == REG_FIFO_STAT)
      begin
        rdata_reg[FST_OVF_BIT] <= ovf_reg;
        rdata_reg[FST_UNF_BIT] <= unf_reg;
        rdata_reg[CW-9:0] <= cnt_reg[CW-1:8];
      end
      else if (link.addr == REG_IO_CFG)
      begin
        rdata_reg[1:0] <= csel_reg;
        rdata_reg[IOC_LF_OFF_BIT] <= lf_off_reg;
        rdata_reg[IOC_STRAP_BIT] <= strap_reg;
      end
    end
  end

  // clock output configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i || set_dflt)
    begin
      csel_reg <= CLKSEL_RESET;
      lf_off_reg <= LF_OFF_RESET;
    end
    else if (link.wr && link.addr == REG_IO_CFG)
    begin
      csel_reg <= clk_sel_t'(link.wdata[1:0]);
      lf_off_reg <= link.wdata[IOC_LF_OFF_BIT];
    end
  end

  // clock output: divided clock with crystal, rc clock without
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reg <= 3'h0;
      mclk_reg <= 1'b0;
      rc_sync_reg <= 3'h0;
      rc_level_reg <= 1'b0;
    end
    else
    begin
      rc_sync_reg <= {rc_sync_reg[1:0], rc_clk_i};
      if (rc_sync_reg[1] == rc_sync_reg[2])
        rc_level_reg <= rc_sync_reg[2];
      div_reg <= div_reg + 3'h1;
      if (xtal_on_i)
      begin
        case (csel_reg)
          CLKSEL_13M56: mclk_reg <= div_reg[0];
          CLKSEL_6M78: mclk_reg <= div_reg[1];
          CLKSEL_3M39: mclk_reg <= div_reg[2];
          default: mclk_reg <= 1'b0;
        endcase
      end
      else
        mclk_reg <= !lf_off_reg && rc_level_reg;
    end
  end

  // interface strap synchronised and followed continuously after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_sync_reg <= 3'h0;
      strap_reg <= 1'b0;
    end
    else
    begin
      strap_sync_reg <= {strap_sync_reg[1:0], i2c_en_i};
      if (strap_sync_reg[1] == strap_sync_reg[2])
        strap_reg <= strap_sync_reg[2];
    end
  end
endmodule

// [rtl/nfc_host_end.sv]
`timescale 1ns/10ps
module nfc_host_end
  import hostirq_pkg::*;
#(
  parameter int TIMEOUT_CYC = RX_TIMEOUT_CYC
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to device
  host_link_if.host link,
  // software command port
  input wire logic [3:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  output logic [7:0] cmd_rdata_o,
  // status
  output logic irq_o,
  output logic timeout_o,
  output logic mcu_tick_o
);
  logic main_due_reg;
  logic cnt_zero_reg;
  logic refused_reg;
  logic [31:0] tmo_reg;
  logic [2:0] mclk_sync_reg;
  logic mclk_level_reg;
  logic stat_rd;
  logic redirect;
  logic refuse;
  logic arm;

  assign stat_rd = cmd_rd_i && is_status(cmd_addr_i);
  assign redirect = stat_rd && main_due_reg;
  assign refuse = stat_rd && !link.irq && cnt_zero_reg;
  assign arm = cmd_wr_i && cmd_addr_i == REG_COMMAND;
  // every transaction starts here; the device never initiates
  assign link.addr = redirect ? REG_STAT_MAIN : cmd_addr_i;
  assign link.wdata = cmd_wdata_i;
  assign link.wr = cmd_wr_i;
  assign link.rd = cmd_rd_i && !refuse;
  assign cmd_rdata_o = refused_reg ? 8'h00 : link.rdata;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_due_reg <= 1'b0;
      cnt_zero_reg <= 1'b1;
      refused_reg <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      refused_reg <= refuse;
      irq_o <= link.irq;
      if (link.irq && !irq_o)
        main_due_reg <= 1'b1;
      else if (redirect)
        main_due_reg <= 1'b0;
      if (refused_reg == 1'b0 && link.rd == 1'b0 && cmd_rd_i == 1'b0)
        cnt_zero_reg <= cnt_zero_reg;
      if (cmd_rd_i && cmd_addr_i == REG_FIFO_CNT)
        cnt_zero_reg <= 1'b0;
      if (link.irq)
        cnt_zero_reg <= 1'b0;
      if (arm)
        cnt_zero_reg <= 1'b1;
    end
  end

  // receive-end watchdog armed by each direct command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmo_reg <= 32'h0000_0000;
      timeout_o <= 1'b0;
    end
    else if (arm)
    begin
      tmo_reg <= 32'(TIMEOUT_CYC);
      timeout_o <= 1'b0;
    end
    else if (link.irq)
      tmo_reg <= 32'h0000_0000;
    else if (tmo_reg != 32'h0000_0000)
    begin
      tmo_reg <= tmo_reg - 32'h0000_0001;
      timeout_o <= tmo_reg == 32'h0000_0001;
    end
  end

  // device clock output sampled as a pin, one tick per rising edge; the one-cycle levels of CLKSEL_13M56 give none
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mclk_sync_reg <= 3'h0;
      mclk_level_reg <= 1'b0;
      mcu_tick_o <= 1'b0;
    end
    else
    begin
      mclk_sync_reg <= {mclk_sync_reg[1:0], link.mcu_clk};
      mcu_tick_o <= 1'b0;
      if (mclk_sync_reg[1] == mclk_sync_reg[2] && mclk_sync_reg[2] != mclk_level_reg)
      begin
        mclk_level_reg <= mclk_sync_reg[2];
        mcu_tick_o <= mclk_sync_reg[2];
      end
    end
  end
endmodule
